/* nco_acc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface nco_acc_if;
	import nco_pkg::*;
	logic [NCO_ACC_W-1:0] freq;
	logic [NCO_PH_W-1:0] phase;
	logic [REFERENCE_DIVISOR_W-1:0] rdiv;
	logic sync;
	logic [NCO_ACC_W-1:0] phase_out;
	logic [NCO_ACC_W-1:0] acc;
	modport ctrl(output freq, phase, rdiv, sync, input phase_out, acc);
	modport acc_side(input freq, phase, rdiv, sync, output phase_out, acc);
endinterface
`default_nettype wire

/* nco_phase_acc.sv */
`timescale 1ns/10ps
`default_nettype none
module nco_phase_acc (
	input wire logic clk_sys,
	input wire logic resetn,
	nco_acc_if.acc_side acc_bus
);
	import nco_pkg::*;

	logic [NCO_ACC_W-1:0] acc_reg;
	logic [NCO_ACC_W-1:0] acc_next;
	logic [REFERENCE_DIVISOR_W-1:0] cnt_reg;
	logic [REFERENCE_DIVISOR_W-1:0] cnt_next;
	logic [NCO_ACC_W-1:0] out_reg;
	logic [NCO_ACC_W-1:0] out_next;
	wire logic div_on;
	wire logic div_wrap;
	wire logic restart;
	wire logic [NCO_ACC_W-1:0] offset_word;

	// A zero divisor leaves a plain modulo 2^32 accumulator; otherwise the
	// phase restarts every rdiv samples so the output period is exact.
	assign div_on = acc_bus.rdiv != REFERENCE_DIVISOR_OFF; // [RL13]
	assign div_wrap = div_on && (cnt_reg >= acc_bus.rdiv - REFERENCE_DIVISOR_ONE);
	assign restart = acc_bus.sync || div_wrap;
	// Unsigned wrap-around addition gives the same bits for a signed word.
	assign acc_next = restart ? NCO_ZERO_W : acc_reg + acc_bus.freq; // [RL1] [RL2] [RL14]
	assign cnt_next = (restart || !div_on) ? REFERENCE_DIVISOR_OFF : cnt_reg + REFERENCE_DIVISOR_ONE;
	// Offset is left justified; one lsb weighs 2^-16 of a full turn.
	assign offset_word = {acc_bus.phase, 16'h0000}; // [RL7] [RL8]
	assign out_next = acc_reg + offset_word; // [RL14]

	// Accumulator, divisor counter and offset output register.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			acc_reg <= NCO_ZERO_W;
			cnt_reg <= REFERENCE_DIVISOR_OFF;
			out_reg <= NCO_ZERO_W;
		end else begin
			acc_reg <= acc_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign acc_bus.phase_out = out_reg;
	assign acc_bus.acc = acc_reg;

	acc_step_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL1]
		!restart |=> acc_reg == $past(acc_reg) + $past(acc_bus.freq))
		else $error("accumulator did not add the frequency word");
	offset_add_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL7]
		1 |=> out_reg == $past(acc_reg) + {$past(acc_bus.phase), 16'h0000})
		else $error("phase offset not added in upper half");
	plain_acc_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL13]
		(acc_bus.rdiv == REFERENCE_DIVISOR_OFF && !acc_bus.sync) |=> cnt_reg == REFERENCE_DIVISOR_OFF
		&& acc_reg == $past(acc_reg) + $past(acc_bus.freq))
		else $error("zero divisor did not give a plain accumulator");
	div_period_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL13]
		(div_on && cnt_reg < acc_bus.rdiv - REFERENCE_DIVISOR_ONE && !acc_bus.sync)
		|=> cnt_reg == $past(cnt_reg) + REFERENCE_DIVISOR_ONE)
		else $error("divisor counter did not advance");
	sync_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL5]
		acc_bus.sync |=> acc_reg == NCO_ZERO_W)
		else $error("sync did not restart the accumulator");
	div_wrap_c: cover property (@(posedge clk_sys) disable iff (!resetn) div_wrap);
endmodule
`default_nettype wire

/* nco_pkg.sv */
`default_nettype none
package nco_pkg;
	// Accumulator, phase offset and divisor widths.
	localparam int NCO_ACC_W = 32;
	localparam int NCO_PH_W = 16;
	localparam int REFERENCE_DIVISOR_W = 16;
	localparam int NCO_PRESETS = 4;
	localparam int NCO_ADDR_W = 12;

	// Byte addresses of the channel A preset words, preset 0 to 3.
	localparam logic [NCO_ADDR_W-1:0] NCO_FREQ_OFF [NCO_PRESETS] = '{
		12'h220, 12'h228, 12'h230, 12'h238};
	localparam logic [NCO_ADDR_W-1:0] NCO_PHASE_OFF [NCO_PRESETS] = '{
		12'h224, 12'h22c, 12'h234, 12'h23c};
	// Read-only view of the live oscillator phase.
	localparam logic [NCO_ADDR_W-1:0] NCO_STATUS_OFF = 12'h280;

	// Reset values and the divisor counter step.
	localparam logic [NCO_ACC_W-1:0] NCO_FREQ_RST = 32'hc000_0000;
	localparam logic [NCO_PH_W-1:0] NCO_PHASE_RST = 16'h0000;
	localparam logic [NCO_ACC_W-1:0] NCO_ZERO_W = 32'h0000_0000;
	localparam logic [REFERENCE_DIVISOR_W-1:0] REFERENCE_DIVISOR_OFF = 16'h0000;
	localparam logic [REFERENCE_DIVISOR_W-1:0] REFERENCE_DIVISOR_ONE = 16'h0001;

	// Slave answer state.
	typedef enum logic {NCO_IDLE, NCO_DONE} nco_apb_st_t;
endpackage
`default_nettype wire

/* nco_preset_a.sv */
// Operation
// [RL1] Output frequency is word over 2^32 times rate.
// [RL2] Word valid as signed or unsigned.
// [RL3] Software computes word as 2^32 times ratio.
// [RL4] Non-integer word: software uses step and divisor.
// [RL5] Rewriting word while running gives arbitrary phase.
// [RL6] Software re-syncs after word change for determinism.
// [RL7] Phase offset left justified, added to accumulator.
// [RL8] Offset weighs 2^-16 turn, signed or unsigned.
// [RL9] Four presets, each frequency word resets C0000000.
// [RL10] Each preset phase offset resets to zero.
// [RL11] Same computation applies to every preset.
// [RL12] Interleaved mode uses channel A settings only.
// [RL13] Zero divisor gives plain 32-bit accumulator.
// [RL14] Accumulator adds selected word, then selected offset.
`timescale 1ns/10ps
`default_nettype none
module nco_preset_a (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [nco_pkg::NCO_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] preset_sel,
	input wire logic nco_sync,
	input wire logic [nco_pkg::REFERENCE_DIVISOR_W-1:0] reference_divisor,
	output logic [nco_pkg::NCO_ACC_W-1:0] nco_phase
);
	import nco_pkg::*;

	logic [NCO_ACC_W-1:0] freq_reg [NCO_PRESETS];
	logic [NCO_PH_W-1:0] phase_reg [NCO_PRESETS];
	nco_apb_st_t st_reg;
	nco_apb_st_t st_next;
	logic [31:0] prdata_reg;
	logic [31:0] rd_mux;
	logic pslverr_reg;
	logic pready_reg;
	wire logic [NCO_PRESETS-1:0] hit_freq;
	wire logic [NCO_PRESETS-1:0] hit_phase;
	wire logic hit_status;
	wire logic hit_any;
	wire logic access;
	wire logic commit;
	wire logic wr_commit;
	wire logic [31:0] byte_mask;

	nco_acc_if acc_bus ();

	// Address decode: each register is one aligned word, so exact match.
	generate
		for (genvar i = 0; i < NCO_PRESETS; i++) begin : g_dec
			assign hit_freq[i] = paddr == NCO_FREQ_OFF[i];
			assign hit_phase[i] = paddr == NCO_PHASE_OFF[i];
		end
	endgenerate
	assign hit_status = paddr == NCO_STATUS_OFF;
	assign hit_any = (|hit_freq) || (|hit_phase) || hit_status;

	// The answer comes one cycle into the access phase; a write lands at the
	// same edge at which the master sees pready, never earlier.
	assign access = psel && penable;
	assign commit = access && (st_reg == NCO_DONE);
	assign wr_commit = commit && pwrite && hit_any;
	assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Answer state: IDLE raises pready next edge, DONE drops it again.
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			NCO_IDLE: begin
				if (access) begin
					st_next = NCO_DONE;
				end
			end
			NCO_DONE: begin
				st_next = NCO_IDLE;
			end
			default: begin
				st_next = NCO_IDLE;
			end
		endcase
	end

	// Read data mux; unused bits above a phase word read as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < NCO_PRESETS; i++) begin
			if (hit_freq[i]) begin
				rd_mux = freq_reg[i];
			end
			if (hit_phase[i]) begin
				rd_mux = {16'h0000, phase_reg[i]};
			end
		end
		if (hit_status) begin
			rd_mux = acc_bus.phase_out;
		end
	end

	// Bus answer registers; read data is captured as pready rises.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= NCO_IDLE;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			pready_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			// Both answer flags come from flops so no decode glitch reaches the pins.
			pready_reg <= st_next == NCO_DONE;
			pslverr_reg <= access && (st_reg == NCO_IDLE) && !hit_any;
			if (access && st_reg == NCO_IDLE) begin
				prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// One identical preset slice per preset, with byte lanes honoured.
	generate
		for (genvar i = 0; i < NCO_PRESETS; i++) begin : g_preset // [RL11]
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					freq_reg[i] <= NCO_FREQ_RST; // [RL9]
					phase_reg[i] <= NCO_PHASE_RST; // [RL10]
				end else if (wr_commit && hit_freq[i]) begin
					freq_reg[i] <= (freq_reg[i] & ~byte_mask) | (pwdata & byte_mask);
				end else if (wr_commit && hit_phase[i]) begin
					phase_reg[i] <= (phase_reg[i] & ~byte_mask[15:0])
						| (pwdata[15:0] & byte_mask[15:0]);
				end
			end
		end
	endgenerate

	// The selected preset feeds the accumulator directly, so a word change
	// takes effect at once with no attempt at phase continuity.
	assign acc_bus.freq = freq_reg[preset_sel]; // [RL14] [RL5]
	assign acc_bus.phase = phase_reg[preset_sel]; // [RL14]
	assign acc_bus.rdiv = reference_divisor;
	assign acc_bus.sync = nco_sync;
	// This block always carries channel A, the set used in interleaved mode.
	assign nco_phase = acc_bus.phase_out; // [RL12]

	nco_phase_acc u_acc (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.acc_bus(acc_bus)
	);

	ready_one_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(access && !pready) |=> pready)
		else $error("pready did not answer one cycle into access");
	ready_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		pready |=> !pready)
		else $error("pready stood longer than one cycle");
	freq_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL9]
		(wr_commit && hit_freq[0] && pstrb == 4'hf) |=> freq_reg[0] == $past(pwdata))
		else $error("frequency word write did not land");
	phase_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL10]
		(wr_commit && hit_phase[1] && pstrb == 4'hf) |=> phase_reg[1] == $past(pwdata[15:0]))
		else $error("phase offset write did not land");
	phase_read_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL10]
		(access && !pready && !pwrite && hit_phase[2]) |=> prdata[31:16] == 16'h0000
		&& prdata[15:0] == phase_reg[2])
		else $error("phase read returned wrong data");
	unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(access && !pready && !hit_any) |=> pslverr && pready)
		else $error("unmapped address not answered with error");
	no_early_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL11]
		(access && !pready && pwrite && hit_freq[3]) |=> freq_reg[3] == $past(freq_reg[3]))
		else $error("write landed before pready");
	sel_feed_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL14]
		(!nco_sync && reference_divisor == REFERENCE_DIVISOR_OFF)
		|=> acc_bus.acc == $past(acc_bus.acc) + $past(freq_reg[preset_sel]))
		else $error("accumulator did not use the selected preset");
	out_chain_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RL7]
		1 |=> nco_phase == $past(acc_bus.acc) + {$past(phase_reg[preset_sel]), 16'h0000})
		else $error("output phase does not carry the selected offset");

	wr_freq_c: cover property (@(posedge clk_sys) disable iff (!resetn) wr_commit && |hit_freq);
	rd_status_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		commit && !pwrite && hit_status);
	sync_c: cover property (@(posedge clk_sys) disable iff (!resetn) nco_sync);
	preset_chg_c: cover property (@(posedge clk_sys) disable iff (!resetn)
		preset_sel != $past(preset_sel));
endmodule
`default_nettype wire

/* nco_preset_frequency_phase_test.sv */
`timescale 1ns/10ps
`default_nettype none
module nco_preset_frequency_phase_test;
	import nco_pkg::*;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, nco_sync, err;
	logic [NCO_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] preset_sel;
	logic [REFERENCE_DIVISOR_W-1:0] reference_divisor;
	logic [NCO_ACC_W-1:0] nco_phase;
	logic [31:0] hist [3];
	int bad_count, n_compared, cyc;

	nco_preset_a dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .preset_sel(preset_sel), .nco_sync(nco_sync),
		.reference_divisor(reference_divisor), .nco_phase(nco_phase));

	// Free-running sample clock at 100 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Cuts a hung run short; the tests need well under a thousand cycles.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end

	// Counts one comparison and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the answer is taken in the last access cycle, so the values seen
	// at the falling edge are those the rising edge that ends the transfer samples.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(negedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, pready, 1'b1);
		end
		r = prdata;
		e = pslverr;
		@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Programs one preset, restarts the accumulator and follows the phase sample by sample.
	task automatic osc_run(input int p, input logic [31:0] f, input logic [15:0] ph);
		logic [31:0] exp;
		apb(1'b1, NCO_FREQ_OFF[p], f, rd, err);
		apb(1'b1, NCO_PHASE_OFF[p], {16'h0000, ph}, rd, err);
		@(posedge clk_sys);
		preset_sel <= p[1:0];
		nco_sync <= 1'b1;
		@(posedge clk_sys);
		nco_sync <= 1'b0;
		exp = {ph, 16'h0000};
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys);
			#1;
			check(nco_phase, exp);
			// A nonzero divisor restarts the phase every divisor samples.
			if (reference_divisor != 16'h0000 && (k + 1) % reference_divisor == 0)
				exp = {ph, 16'h0000};
			else
				exp = exp + f;
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence; every input is given a value at time zero.
	initial begin
		{resetn, psel, penable, pwrite, nco_sync, bad_count, n_compared} = '0;
		{paddr, pwdata, preset_sel, reference_divisor} = '0;
		pstrb = 4'hf;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int p = 0; p < NCO_PRESETS; p++) begin
			apb(1'b0, NCO_FREQ_OFF[p], 32'h0000_0000, rd, err);
			check(rd, 32'hc000_0000);
			apb(1'b0, NCO_PHASE_OFF[p], 32'h0000_0000, rd, err);
			check(rd, 32'h0000_0000);
		end
		$display("test reset values done");
		// Distinct data per preset catches swapped or aliased address decoding.
		for (int p = 0; p < NCO_PRESETS; p++) begin
			apb(1'b1, NCO_FREQ_OFF[p], 32'h1357_9bd0 + p, rd, err);
			check({31'h0, err}, 32'h0000_0000);
			apb(1'b1, NCO_PHASE_OFF[p], 32'hffff_a5c0 + p, rd, err);
		end
		for (int p = 0; p < NCO_PRESETS; p++) begin
			apb(1'b0, NCO_FREQ_OFF[p], 32'h0000_0000, rd, err);
			check(rd, 32'h1357_9bd0 + p);
			apb(1'b0, NCO_PHASE_OFF[p], 32'h0000_0000, rd, err);
			check(rd, 32'h0000_a5c0 + p);
		end
		$display("test register access done");
		apb(1'b0, 12'h240, 32'h0000_0000, rd, err);
		check(rd, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		apb(1'b1, NCO_STATUS_OFF, 32'h0000_0000, rd, err);
		check({31'h0, err}, 32'h0000_0000);
		$display("test unmapped address done");
		osc_run(0, 32'h0000_1000, 16'h8000);
		osc_run(1, 32'hffff_fff0, 16'h0001);
		osc_run(2, 32'h8000_0001, 16'h4000);
		osc_run(3, 32'h4000_0000, 16'hffff);
		$display("test oscillator presets done");
		// With a divisor of three the phase must repeat every three samples.
		reference_divisor <= 16'h0003;
		osc_run(2, 32'h0123_4567, 16'h0010);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			#1;
			hist[k] = nco_phase;
		end
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys);
			#1;
			check(nco_phase, hist[k % 3]);
		end
		$display("test divisor done");
		test_done();
	end
endmodule
`default_nettype wire
